// >>> pkg/ssr_pkg.sv
// Package for the synchronous serial receiver: register map, fields, reset values, timing and carriers.
package ssr_pkg;
    // Register indices on the plain register port.
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] STAT_ADDR = 2'h1;
    localparam logic [1:0] DATA_ADDR = 2'h2;
    // Control register field positions.
    localparam int CTRL_PORT_EN = 0;
    localparam int CTRL_SYNC = 1;
    localparam int CTRL_CLK_SRC = 2;
    localparam int CTRL_SINGLE = 3;
    localparam int CTRL_CONT = 4;
    localparam int CTRL_NINE = 5;
    localparam int CTRL_IRQ_EN = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Status register field positions.
    localparam int STAT_NINTH = 0;
    localparam int STAT_OVERRUN = 1;
    localparam int STAT_COMPLETE = 2;
    localparam int STAT_COUNT = 3;
    // Master clock: half period of the generated serial clock.
    localparam int HALF_PERIOD_NS = 400;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int HALF_CYCLES = (HALF_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int FIFO_DEPTH = 2;
    // Serial clocks per character for eight-bit and nine-bit reception.
    localparam logic [3:0] BITS_NORMAL = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;

    // Control bits as software sees them.
    typedef struct packed {
        logic irqEn;
        logic nineBit;
        logic contEn;
        logic singleEn;
        logic clkSrc;
        logic syncMode;
        logic portEn;
    } ssr_ctrl_t;

    // One received character: ninth bit and low byte.
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } ssr_char_t;
endpackage

// >>> logic/ssr_receiver.sv
// Synchronous serial receiver: master or slave clocking, two-entry FIFO, overrun and ninth bit.
`timescale 1ns/10ps
//
// Contract
// - In synchronous master receive the data pin driver is turned off.
// - Reception starts when single or continuous receive enable is set.
// - Single receive emits one character of clocks, then clears its own enable.
// - Continuous receive clocks until cleared; clearing mid-character stops clock, drops partial.
// - With both enables set, single clears after first character; continuous continues.
// - Data pin is sampled on the trailing clock edge into the shift register.
// - A full character sets the complete flag and moves into the FIFO.
// - Data register shows oldest character; complete flag holds while FIFO non-empty.
// - As slave, clock comes from the clock pin whose driver is disabled.
// - Sender changes data on leading edge; one bit per clock.
// - A third character with FIFO full sets overrun and keeps FIFO contents.
// - While overrun, stored characters stay readable and no new ones are taken.
// - Overrun from single receive clears on a data register read.
// - Overrun from continuous receive clears on continuous or port enable clear.
// - Nine-bit select shifts nine bits per character.
// - Ninth bit of the oldest character shows in the status register.
// - Receive interrupt is raised only when its enable is set.
module ssr_receiver #(
    parameter int HALF_CYCLES = ssr_pkg::HALF_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic rxDataPinIn,
    output logic rxDataPinOut,
    output logic rxDataPinOe,
    input wire logic txClockPinIn,
    output logic txClockPinOut,
    output logic txClockPinOe,
    output logic receiveIrq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Control register and derived modes.
    ssr_pkg::ssr_ctrl_t ctrl_q;
    logic master;
    logic receiving;
    logic charDone;
    logic bitTake;
    logic popFifo;
    logic pushFifo;
    logic fifoFull;
    logic completeFlag;
    logic overrun_q;
    logic overrunFromCont_q;
    logic [1:0] count_q;

    // Receive shift register, bit counter and the synchronised pins.
    logic [8:0] shift_q;
    logic [8:0] newChar;
    logic [3:0] bitCnt_q;
    logic [1:0] clkSync_q;
    logic [1:0] dataSync_q;
    logic clkPrev_q;

    // Master clock generator.
    logic sclk_q;
    logic [15:0] halfCnt_q;
    logic [3:0] genCnt_q;
    logic genStop_q;
    logic halfDone;

    // Two-entry receive FIFO and the read port.
    ssr_pkg::ssr_char_t fifo_q [ssr_pkg::FIFO_DEPTH];
    ssr_pkg::ssr_char_t headChar;
    logic rdPtr_q;
    logic wrPtr_q;
    logic [7:0] regRdData_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Number of serial clocks in one character for the given nine-bit setting.
    function automatic logic [3:0] charBits(input logic nine);
        charBits = nine ? ssr_pkg::BITS_NINE : ssr_pkg::BITS_NORMAL;
    endfunction

    // Packs the status fields at their positions; unused bits read as zero.
    function automatic logic [7:0] statusWord(
        input logic ninth,
        input logic ovr,
        input logic cmpl,
        input logic [1:0] cnt
    );
        statusWord = 8'h00;
        statusWord[ssr_pkg::STAT_NINTH] = ninth;
        statusWord[ssr_pkg::STAT_OVERRUN] = ovr;
        statusWord[ssr_pkg::STAT_COMPLETE] = cmpl;
        statusWord[ssr_pkg::STAT_COUNT +: 2] = cnt;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decoding.

    // The block drives the serial clock only as a synchronous master.
    assign master = ctrl_q.portEn && ctrl_q.syncMode && ctrl_q.clkSrc;
    // Reception runs only while enabled, the port is on and no overrun blocks it.
    assign receiving = ctrl_q.portEn && ctrl_q.syncMode && (ctrl_q.singleEn || ctrl_q.contEn) && !overrun_q;
    assign popFifo = regRead && (regAddr == ssr_pkg::DATA_ADDR) && (count_q != 2'h0);
    assign fifoFull = (count_q == 2'(ssr_pkg::FIFO_DEPTH));
    // The complete flag is the FIFO's occupancy, so software clears it only by reading the data register or by clearing the port enable.
    assign completeFlag = (count_q != 2'h0);

    // Software writes the control bits; single enable also clears itself after one character.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= ssr_pkg::ssr_ctrl_t'(ssr_pkg::CTRL_RESET[6:0]);
        end else if (regWrite && regAddr == ssr_pkg::CTRL_ADDR) begin
            ctrl_q <= ssr_pkg::ssr_ctrl_t'(regWrData[6:0]);
        end else if (charDone && ctrl_q.singleEn) begin
            ctrl_q.singleEn <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    // Both pins come from outside this clock domain and pass two flip-flops first.
    // Clock and data go through equal delays, so their relation at the pin is kept.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clkSync_q <= 2'h0;
            dataSync_q <= 2'h0;
        end else begin
            clkSync_q <= {clkSync_q[0], txClockPinIn};
            dataSync_q <= {dataSync_q[0], rxDataPinIn};
        end
    end

    // Previous synchronised clock level for edge detection; it resets to the idle low level.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clkPrev_q <= 1'b0;
        end else begin
            clkPrev_q <= clkSync_q[1];
        end
    end

    // A trailing (falling) edge of the serial clock takes one bit, but only while receiving.
    // Edges that arrive after reception was switched off are ignored on purpose.
    assign bitTake = receiving && clkPrev_q && !clkSync_q[1];
    assign charDone = bitTake && (bitCnt_q == charBits(ctrl_q.nineBit) - 4'h1);
    // A finished character enters the FIFO unless both entries are taken.
    assign pushFifo = charDone && !fifoFull;

    ////////////////////////////////////////////////////////////////////////////////
    // Master clock generator.

    assign halfDone = (halfCnt_q == 16'(HALF_CYCLES - 1));

    // The clock idles low, so the rising edge leads and the falling edge trails.
    // Single receive stops after one character; continuous keeps running.
    // Dropping the enables stops the clock at once, mid-character included.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            halfCnt_q <= 16'h0000;
            sclk_q <= 1'b0;
            genCnt_q <= 4'h0;
            genStop_q <= 1'b0;
        end else if (!(master && receiving)) begin
            halfCnt_q <= 16'h0000;
            sclk_q <= 1'b0;
            genCnt_q <= 4'h0;
            genStop_q <= 1'b0;
        end else if (genStop_q) begin
            halfCnt_q <= 16'h0000;
        end else if (halfDone) begin
            halfCnt_q <= 16'h0000;
            sclk_q <= !sclk_q;
            if (sclk_q) begin
                if (genCnt_q == charBits(ctrl_q.nineBit) - 4'h1) begin
                    genCnt_q <= 4'h0;
                    genStop_q <= !ctrl_q.contEn;
                end else begin
                    genCnt_q <= genCnt_q + 4'h1;
                end
            end
        end else begin
            halfCnt_q <= halfCnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive shift register.

    // The current bit is placed at its position, least significant bit first.
    always_comb begin
        newChar = shift_q;
        newChar[bitCnt_q] = dataSync_q[1];
    end

    // A partial character is thrown away whenever reception stops.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_q <= 4'h0;
            shift_q <= 9'h000;
        end else if (!receiving) begin
            bitCnt_q <= 4'h0;
            shift_q <= 9'h000;
        end else if (charDone) begin
            bitCnt_q <= 4'h0;
            shift_q <= 9'h000;
        end else if (bitTake) begin
            bitCnt_q <= bitCnt_q + 4'h1;
            shift_q <= newChar;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive FIFO.

    // Pointers and occupancy; clearing the port enable empties the FIFO.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 2'h0;
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
        end else if (!ctrl_q.portEn) begin
            count_q <= 2'h0;
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
        end else begin
            if (pushFifo) begin
                wrPtr_q <= !wrPtr_q;
            end
            if (popFifo) begin
                rdPtr_q <= !rdPtr_q;
            end
            if (pushFifo && !popFifo) begin
                count_q <= count_q + 2'h1;
            end else if (popFifo && !pushFifo) begin
                count_q <= count_q - 2'h1;
            end
        end
    end

    // Character storage; the ninth bit is kept only in nine-bit mode.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ssr_pkg::FIFO_DEPTH; i++) begin
                fifo_q[i] <= '0;
            end
        end else if (pushFifo) begin
            fifo_q[wrPtr_q].ninth <= ctrl_q.nineBit && newChar[8];
            fifo_q[wrPtr_q].data <= newChar[7:0];
        end
    end

    // The oldest character sits at the read pointer.
    assign headChar = fifo_q[rdPtr_q];

    ////////////////////////////////////////////////////////////////////////////////
    // Overrun error.

    // Setting wins over any clear; while set, reception is blocked and the FIFO is kept.
    // The mode at the time of the error decides which action clears it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            overrun_q <= 1'b0;
            overrunFromCont_q <= 1'b0;
        end else if (charDone && fifoFull) begin
            overrun_q <= 1'b1;
            overrunFromCont_q <= ctrl_q.contEn;
        end else if (!ctrl_q.portEn) begin
            overrun_q <= 1'b0;
        end else if (overrun_q && overrunFromCont_q && !ctrl_q.contEn) begin
            overrun_q <= 1'b0;
        end else if (overrun_q && !overrunFromCont_q && popFifo) begin
            overrun_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port.

    // Read data stand for the one cycle after the read strobe, and are zero otherwise.
    // The ninth bit reads zero when the FIFO is empty, so a stale entry never shows.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            regRdData_q <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                ssr_pkg::CTRL_ADDR: begin
                    regRdData_q <= {1'b0, ctrl_q};
                end
                ssr_pkg::STAT_ADDR: begin
                    regRdData_q <= statusWord(completeFlag && headChar.ninth, overrun_q, completeFlag, count_q);
                end
                ssr_pkg::DATA_ADDR: begin
                    regRdData_q <= headChar.data;
                end
                default: begin
                    regRdData_q <= 8'h00;
                end
            endcase
        end else begin
            regRdData_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign regRdData = regRdData_q;
    // This block only receives, so the data pin driver is never on.
    assign rxDataPinOut = 1'b0;
    assign rxDataPinOe = 1'b0;
    // The clock pin is driven only as master; as slave it is an input.
    assign txClockPinOut = sclk_q;
    assign txClockPinOe = master;
    // The request follows the complete flag and is gated by its enable.
    assign receiveIrq = completeFlag && ctrl_q.irqEn;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking assertClk @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // A character finishes while both entries are occupied.
    sequence fullArrival;
        charDone && fifoFull;
    endsequence

    // Software reads the data register under an overrun raised in single mode.
    sequence singleOverrunRead;
        overrun_q && !overrunFromCont_q && popFifo;
    endsequence

    // Continuous enable is dropped under an overrun raised in continuous mode.
    sequence contOverrunDropped;
        overrun_q && overrunFromCont_q && ctrl_q.portEn && !ctrl_q.contEn;
    endsequence

    data_drive_a: assert property (!rxDataPinOe)
        else $error("Data pin driver enabled during reception.");

    single_clear_a: assert property (charDone && ctrl_q.singleEn && !(regWrite && regAddr == ssr_pkg::CTRL_ADDR)
        |=> !ctrl_q.singleEn)
        else $error("Single receive enable did not clear after a character.");

    clock_stop_a: assert property (!receiving |=> !sclk_q)
        else $error("Serial clock still high after reception stopped.");

    slave_drive_a: assert property (!master |-> !txClockPinOe)
        else $error("Clock pin driven while not master.");

    overrun_set_a: assert property (fullArrival |=> overrun_q)
        else $error("Overrun not raised for a character at a full FIFO.");

    overrun_hold_a: assert property (overrun_q && ctrl_q.portEn && !popFifo |=> count_q == $past(count_q))
        else $error("FIFO occupancy changed during overrun.");

    overrun_read_a: assert property (singleOverrunRead |=> !overrun_q)
        else $error("Single mode overrun not cleared by a data read.");

    overrun_cont_a: assert property (contOverrunDropped |=> !overrun_q)
        else $error("Continuous mode overrun not cleared by dropping the enable.");

    complete_clear_a: assert property (popFifo && count_q == 2'h1 && !pushFifo |=> !completeFlag)
        else $error("Complete flag still set after the FIFO emptied.");
endmodule

// >>> tb/ssr_tx_model.sv
// Far-side transmitter model: shifts one word out LSB first.
`timescale 1ns/10ps
module ssr_tx_model (
    input wire logic serClk,
    input wire logic [8:0] word,
    input wire logic load,
    output logic dataOut
);
    int idx = 9;
    initial dataOut = 1'b0;
    // New bit on the leading edge; line toggles when idle so stale data never looks valid.
    always @(posedge serClk or posedge load) begin
        if (load) idx <= 0;
        else begin
            dataOut <= (idx < 9) ? word[idx] : ~dataOut;
            idx <= idx + 1;
        end
    end
endmodule

// >>> tb/tb.sv
// Testbench: master single and slave continuous receive.
`timescale 1ns/10ps
module tb;
    logic clock = 0, reset_n = 0, regWrite = 0, regRead = 0, load = 0, sClk = 0, mData, ro, rOe, co, cOe, irq;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00, regRdData, d;
    logic [8:0] word = 9'h000;
    int n_errors = 0, comparisons = 0;
    wire serLine = cOe ? co : sClk;
    wire dLine = rOe ? ro : mData;
    ssr_receiver #(.HALF_CYCLES(4)) uut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxDataPinIn(dLine), .rxDataPinOut(ro),
        .rxDataPinOe(rOe), .txClockPinIn(serLine), .txClockPinOut(co), .txClockPinOe(cOe), .receiveIrq(irq));
    ssr_tx_model model (.serClk(serLine), .word(word), .load(load), .dataOut(mData));
    // System clock.
    always #5 clock = ~clock;
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        {regAddr, regWrData, regWrite} <= {a, v, 1'b1};
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task rd(input logic [1:0] a);
        @(posedge clock);
        {regAddr, regRead} <= {a, 1'b1};
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task wait_rx;
        d = 8'h00;
        for (int i = 0; i < 300 && d[ssr_pkg::STAT_COMPLETE] !== 1'b1; i++) rd(ssr_pkg::STAT_ADDR);
    endtask
    // External master: reload the model, then n link clocks of 80 ns, edges on system clock edges.
    task slave_char(input logic [8:0] w, input int n);
        {word, load} <= {w, 1'b1};
        @(posedge clock);
        load <= 1'b0;
        repeat (2 * n) begin
            repeat (4) @(posedge clock);
            sClk <= ~sClk;
        end
        repeat (8) @(posedge clock);
    endtask
    task test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog: all frames of the test together need well under this span.
    initial begin
        #100000 n_errors++;
        test_done;
    end
    // Master single, then slave continuous with an 80 ns link clock.
    initial begin
        repeat (12) @(posedge clock);
        {reset_n, word, load} <= {1'b1, 9'h0a5, 1'b1};
        wr(ssr_pkg::CTRL_ADDR, 8'h0f);
        load <= 1'b0;
        wait_rx;
        chk("dataOe", 8'h00, {7'h00, rOe});
        chk("irqOff", 8'h00, {7'h00, irq});
        rd(ssr_pkg::DATA_ADDR);
        chk("master", 8'ha5, d);
        rd(ssr_pkg::CTRL_ADDR);
        chk("ctrl", 8'h07, d);
        wr(ssr_pkg::CTRL_ADDR, 8'h13);
        slave_char(9'h03c, 8);
        wait_rx;
        chk("clkOe", 8'h00, {7'h00, cOe});
        rd(ssr_pkg::DATA_ADDR);
        chk("slave", 8'h3c, d);
        // Three characters with no read: the third raises overrun and is dropped.
        slave_char(9'h011, 8);
        slave_char(9'h022, 8);
        slave_char(9'h033, 8);
        rd(ssr_pkg::STAT_ADDR);
        chk("statOvr", 8'h16, d);
        rd(ssr_pkg::DATA_ADDR);
        chk("ovrFirst", 8'h11, d);
        rd(ssr_pkg::STAT_ADDR);
        chk("statOne", 8'h0e, d);
        rd(ssr_pkg::DATA_ADDR);
        chk("ovrSecond", 8'h22, d);
        rd(ssr_pkg::STAT_ADDR);
        chk("statEmpty", 8'h02, d);
        wr(ssr_pkg::CTRL_ADDR, 8'h03);
        rd(ssr_pkg::STAT_ADDR);
        chk("ovrClear", 8'h00, d);
        // Nine-bit master single receive with the interrupt enabled.
        {word, load} <= {9'h15a, 1'b1};
        wr(ssr_pkg::CTRL_ADDR, 8'h6f);
        load <= 1'b0;
        wait_rx;
        chk("irqOn", 8'h01, {7'h00, irq});
        chk("statNine", 8'h0d, d);
        rd(ssr_pkg::DATA_ADDR);
        chk("nine", 8'h5a, d);
        chk("irqEmpty", 8'h00, {7'h00, irq});
        // Continuous master receive cut mid-character: clock stops, nothing is kept.
        {word, load} <= {9'h0ff, 1'b1};
        wr(ssr_pkg::CTRL_ADDR, 8'h17);
        load <= 1'b0;
        repeat (30) @(posedge clock);
        wr(ssr_pkg::CTRL_ADDR, 8'h07);
        repeat (100) @(posedge clock);
        chk("clkStop", 8'h00, {7'h00, co});
        rd(ssr_pkg::STAT_ADDR);
        chk("cutChar", 8'h00, d);
        test_done;
    end
endmodule
